// ==== ltt_defs.svh ====
// Constants for the lock end and transfer tracker.
// Operation
// - Tracker derives lock end from visible bus
// - Count every completed read in locked sequence
// - Lock end during write matching read count
// - Failed dual swap miscounts; accepted limitation
// - Straddling swap correct only if first dirty
// - Idle waits; address states for locked phases
// - Nonburst transfer holds in data state
// - Burst tracked through four data states
// - First data state shared; three more follow
// - Latches hold right after strobe edge
// - Grant loss tristates address after completion
// - Finish transfer or locked sequence before release
// - One idle clock between target cycles
// - Outward strobe delayed exactly one clock
// - Progress and strobe outputs are registered
// - Lock end output is registered
// - Fully synchronous machine, clocked outputs
// - Inhibited bursts are not tracked
// - Lock negated at completion returns idle
// - Retry on later burst transfers is error
// - Progress output released when bus relinquished
`ifndef LTT_DEFS_SVH
`define LTT_DEFS_SVH

`define LTT_DIR_READ 1'b1
`define LTT_SIZE_LINE 2'h3
`define LTT_CNT_STEP 1
`define LTT_CNT_WIDTH 3
`define LTT_CNT_MIN_WIDTH 2
`define LTT_ALE_RST 1'b1
`define LTT_FLAG_RST 1'b0

`endif

// ==== ltt_pkg.sv ====
// Types shared by the lock end and transfer tracker.
package ltt_pkg;

    typedef enum logic [2:0] {
        LTT_IDLE,
        LTT_DATA0,
        LTT_BURST1,
        LTT_BURST2,
        LTT_BURST3,
        LTT_LK_ADDR,
        LTT_LK_DATA
    } ltt_state_e;

endpackage : ltt_pkg

// ==== ltt_cnt_if.sv ====
// Carrier between the tracker sequencer and its transfer counter.
`timescale 1ns/1ps
interface ltt_cnt_if;
    logic clear;
    logic read_inc;
    logic write_inc;
    logic match_next;
    logic any_read;

    modport ctrl
    (
        output clear,
        output read_inc,
        output write_inc,
        input match_next,
        input any_read
    );

    modport cnt
    (
        input clear,
        input read_inc,
        input write_inc,
        output match_next,
        output any_read
    );
endinterface : ltt_cnt_if

// ==== ltt_counter.sv ====
// Read and write counter of a locked sequence.
`timescale 1ns/1ps
`include "ltt_defs.svh"
module ltt_counter #(
    parameter int CNT_W = `LTT_CNT_WIDTH
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Sequencer side
    ltt_cnt_if.cnt cnt_if
);
    import ltt_pkg::*;

    localparam logic [CNT_W-1:0] STEP = CNT_W'(`LTT_CNT_STEP);

    logic [CNT_W-1:0] rd_count_reg;
    logic [CNT_W-1:0] wr_count_reg;

    // ************************************************************
    // Elaboration check
    // ************************************************************
    generate
        if (CNT_W < `LTT_CNT_MIN_WIDTH)
        begin : g_bad_width
            $error("ltt_counter: CNT_W too small");
        end
    endgenerate

    // ************************************************************
    // Counters
    // ************************************************************
    // Operands vary in size and alignment, so reads are counted.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rd_count_reg <= '0;
        else if (cnt_if.clear)
            rd_count_reg <= '0;
        else if (cnt_if.read_inc)
            rd_count_reg <= rd_count_reg + STEP;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            wr_count_reg <= '0;
        else if (cnt_if.clear)
            wr_count_reg <= '0;
        else if (cnt_if.write_inc)
            wr_count_reg <= wr_count_reg + STEP;
    end

    // The next write is the last one when its ordinal equals the reads.
    assign cnt_if.match_next = (wr_count_reg + STEP) == rd_count_reg;
    assign cnt_if.any_read = rd_count_reg != '0;

    // ************************************************************
    // Checks
    // ************************************************************
    read_count_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        cnt_if.read_inc && !cnt_if.clear
        |=> rd_count_reg == $past(rd_count_reg) + STEP)
        else $error("read count did not advance");

    clear_count_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        cnt_if.clear |=> rd_count_reg == '0 && wr_count_reg == '0)
        else $error("counters not cleared");

endmodule : ltt_counter

// ==== ltt_top.sv ====
// Sequencer that regenerates strobe, progress and lock end signals.
`timescale 1ns/1ps
`include "ltt_defs.svh"
module ltt_top #(
    parameter int CNT_W = `LTT_CNT_WIDTH
)
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic ARST_N,
    // Processor side
    input wire logic PROC_RESET_N,
    input wire logic TRANSFER_START_STROBE_N,
    input wire logic CYCLE_ACKNOWLEDGE_N,
    input wire logic BUS_ERROR_N,
    input wire logic GRANT_INPUT_N,
    input wire logic READ_WRITE,
    input wire logic [1:0] SIZE,
    input wire logic LOCK_N,
    // Target board side
    output logic TRANSFER_START_STROBE_OUT_N,
    output logic LOCK_END_N,
    input wire logic TRANSFER_IN_PROGRESS_BIDIR_N_I,
    output logic TRANSFER_IN_PROGRESS_BIDIR_N_O,
    output logic TRANSFER_IN_PROGRESS_BIDIR_N_OE,
    // Address latch control
    output logic ADDRESS_LATCH_ENABLE,
    output logic ADDRESS_OUTPUT_ENABLE
);
    import ltt_pkg::*;

    ltt_state_e state_reg;
    ltt_state_e state_next;
    logic strobe_out_reg;
    logic tip_reg;
    logic locke_reg;
    logic locke_next;
    logic ale_reg;
    logic owned_reg;
    logic owned_next;
    logic pend_reg;
    logic cap_rd_reg;
    logic cap_lock_reg;
    logic cap_burst_reg;
    logic line_busy_reg;
    logic strobe;
    logic cur_rd;
    logic cur_lock;
    logic ack;
    logic err;
    logic lock;
    logic start;
    logic in_data;
    logic data_next;

    ltt_cnt_if cnt_if ();

    // ************************************************************
    // Decoding
    // ************************************************************
    // A data state is one in which a transfer is on the target bus.
    function automatic logic is_data(input ltt_state_e s);
        is_data = (s != LTT_IDLE) && (s != LTT_LK_ADDR);
    endfunction : is_data

    // A retry reaches us as acknowledge with error; it aborts too.
    assign strobe = !TRANSFER_START_STROBE_N;
    assign err = !BUS_ERROR_N;
    assign ack = !CYCLE_ACKNOWLEDGE_N && !err;
    assign lock = !LOCK_N;
    assign in_data = is_data(state_reg);
    assign data_next = is_data(state_next);
    // A strobe seen during the completing edge is kept pending so that
    // the target still gets the idle clock between cycles.
    assign start = (strobe || pend_reg) && owned_reg;
    assign cur_rd = strobe ? (READ_WRITE == `LTT_DIR_READ) : cap_rd_reg;
    assign cur_lock = strobe ? lock : cap_lock_reg;

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Bursts cut short by inhibit are not followed; the processor is
    // expected to finish such a line with single transfers.
    always_comb
    begin
        state_next = state_reg;
        cnt_if.clear = 1'b0;
        cnt_if.read_inc = 1'b0;
        cnt_if.write_inc = 1'b0;
        if (!PROC_RESET_N)
        begin
            state_next = LTT_IDLE;
            cnt_if.clear = 1'b1;
        end
        else
        begin
            unique case (state_reg)
                LTT_IDLE:
                begin
                    if (start)
                        state_next = cur_lock ? LTT_LK_DATA : LTT_DATA0;
                end
                LTT_DATA0:
                begin
                    if (err)
                        state_next = LTT_IDLE;
                    else if (ack)
                        state_next = cap_burst_reg ? LTT_BURST1 : LTT_IDLE;
                end
                LTT_BURST1:
                begin
                    if (err)
                        state_next = LTT_IDLE;
                    else if (ack)
                        state_next = LTT_BURST2;
                end
                LTT_BURST2:
                begin
                    if (err)
                        state_next = LTT_IDLE;
                    else if (ack)
                        state_next = LTT_BURST3;
                end
                LTT_BURST3:
                begin
                    if (err || ack)
                        state_next = LTT_IDLE;
                end
                LTT_LK_ADDR:
                begin
                    if (!lock)
                    begin
                        state_next = LTT_IDLE;
                        cnt_if.clear = 1'b1;
                    end
                    else if (start)
                        state_next = LTT_LK_DATA;
                end
                LTT_LK_DATA:
                begin
                    if (err)
                    begin
                        state_next = LTT_IDLE;
                        cnt_if.clear = 1'b1;
                    end
                    else if (ack && !lock)
                    begin
                        state_next = LTT_IDLE;
                        cnt_if.clear = 1'b1;
                    end
                    else if (ack && cap_rd_reg)
                    begin
                        state_next = LTT_LK_ADDR;
                        cnt_if.read_inc = 1'b1;
                    end
                    else if (ack && (locke_reg || !cnt_if.any_read))
                    begin
                        state_next = LTT_IDLE;
                        cnt_if.clear = 1'b1;
                    end
                    else if (ack)
                    begin
                        state_next = LTT_LK_ADDR;
                        cnt_if.write_inc = 1'b1;
                    end
                end
                default:
                begin
                    state_next = LTT_IDLE;
                    cnt_if.clear = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
            state_reg <= LTT_IDLE;
        else
            state_reg <= state_next;
    end

    ltt_counter #(
        .CNT_W(CNT_W)
    ) u_counter (
        .mclk(MCLK),
        .arst_n(ARST_N),
        .cnt_if(cnt_if.cnt)
    );

    // ************************************************************
    // Transfer attributes and pending strobe
    // ************************************************************
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            cap_rd_reg <= `LTT_FLAG_RST;
            cap_lock_reg <= `LTT_FLAG_RST;
            cap_burst_reg <= `LTT_FLAG_RST;
        end
        else if (strobe)
        begin
            cap_rd_reg <= READ_WRITE == `LTT_DIR_READ;
            cap_lock_reg <= lock;
            cap_burst_reg <= (SIZE == `LTT_SIZE_LINE) && !lock;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
            pend_reg <= `LTT_FLAG_RST;
        else if (!PROC_RESET_N || (data_next && !in_data))
            pend_reg <= `LTT_FLAG_RST;
        else if (strobe && in_data)
            pend_reg <= 1'b1;
    end

    // ************************************************************
    // Registered bus outputs
    // ************************************************************
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
            strobe_out_reg <= `LTT_FLAG_RST;
        else
            strobe_out_reg <= strobe;
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
            tip_reg <= `LTT_FLAG_RST;
        else
            tip_reg <= data_next;
    end

    // The lock end rises with the matching write and falls with it.
    always_comb
    begin
        locke_next = 1'b0;
        if (state_next == LTT_LK_DATA && !cur_rd)
            locke_next = in_data ? locke_reg : cnt_if.match_next;
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
            locke_reg <= `LTT_FLAG_RST;
        else
            locke_reg <= locke_next;
    end

    // Latches close right after the edge that samples the strobe and
    // stay closed until the transfer is done.
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
            ale_reg <= `LTT_ALE_RST;
        else
            ale_reg <= PROC_RESET_N && !strobe && !data_next && !start;
    end

    // The line is sampled only on rising edges; other drivers must be
    // settled by then.
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
            line_busy_reg <= `LTT_FLAG_RST;
        else
            line_busy_reg <= !TRANSFER_IN_PROGRESS_BIDIR_N_I;
    end

    // Ownership changes only between cycles and outside locked runs.
    always_comb
    begin
        owned_next = owned_reg;
        if (state_reg == LTT_IDLE && !pend_reg && !start)
            owned_next = !GRANT_INPUT_N && (owned_reg || !line_busy_reg);
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
            owned_reg <= `LTT_FLAG_RST;
        else
            owned_reg <= owned_next;
    end

    assign TRANSFER_START_STROBE_OUT_N = !strobe_out_reg;
    assign LOCK_END_N = !locke_reg;
    assign TRANSFER_IN_PROGRESS_BIDIR_N_O = !tip_reg;
    assign TRANSFER_IN_PROGRESS_BIDIR_N_OE = owned_reg;
    assign ADDRESS_LATCH_ENABLE = ale_reg;
    assign ADDRESS_OUTPUT_ENABLE = owned_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);

    strobe_delay_a: assert property ($past(strobe) == strobe_out_reg)
        else $error("outward strobe not one clock late");
    locke_write_a: assert property (
        locke_reg |-> state_reg == LTT_LK_DATA && !cap_rd_reg)
        else $error("lock end outside a locked write");
    error_idle_a: assert property (
        in_data && err && PROC_RESET_N |=> state_reg == LTT_IDLE)
        else $error("bus error did not return to idle");
    unlock_idle_a: assert property (
        state_reg == LTT_LK_DATA && ack && !lock |=> state_reg == LTT_IDLE)
        else $error("abandoned lock not released");
    burst_end_a: assert property (
        state_reg == LTT_BURST3 && ack && PROC_RESET_N
        |=> state_reg == LTT_IDLE)
        else $error("burst not closed after four transfers");
    dead_clock_a: assert property (
        $rose(tip_reg) |-> $past(state_reg) inside {LTT_IDLE, LTT_LK_ADDR})
        else $error("no idle clock before transfer");
    grant_hold_a: assert property (
        owned_reg && state_reg != LTT_IDLE |=> owned_reg)
        else $error("outputs released mid sequence");
    tip_release_a: assert property (
        !owned_reg |-> !tip_reg && !TRANSFER_IN_PROGRESS_BIDIR_N_OE)
        else $error("progress line driven without bus");
    latch_hold_a: assert property (strobe |=> !ale_reg)
        else $error("latch open after strobe");

    burst_cov: cover property (state_reg == LTT_BURST3 && ack);
    locke_cov: cover property ($rose(locke_reg));
    lock_read_cov: cover property (cnt_if.read_inc ##[1:20] cnt_if.read_inc);
    grant_cov: cover property ($fell(owned_reg));

endmodule : ltt_top

// ==== ltt_target_model.sv ====
// Target board model that terminates the regenerated transfers.
`timescale 1ns/1ps
module ltt_target_model
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Resolved progress line
    input wire logic tip_line_n,
    // Scenario control
    input wire logic [1:0] wait_cycles,
    input wire logic [1:0] fault_mode,
    input wire logic [1:0] fault_at,
    // Terminations
    output logic ack_n,
    output logic err_n
);
    logic [1:0] wait_reg;
    logic [1:0] beat_reg;
    logic hit;

    // Mode 1 is a bus error, mode 2 a retry on the chosen beat.
    assign hit = (fault_mode != 2'h0) && (beat_reg == fault_at);

    // The line is only looked at on rising edges, never between them.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_n <= 1'b1;
            err_n <= 1'b1;
            wait_reg <= 2'h0;
            beat_reg <= 2'h0;
        end
        else if (!ack_n || !err_n)
        begin
            // One-cycle terminations keep a beat from being counted twice.
            ack_n <= 1'b1;
            err_n <= 1'b1;
            wait_reg <= 2'h0;
            beat_reg <= beat_reg + 2'h1;
        end
        else if (tip_line_n)
        begin
            wait_reg <= 2'h0;
            beat_reg <= 2'h0;
        end
        else if (wait_reg == wait_cycles)
        begin
            ack_n <= hit && (fault_mode == 2'h1);
            err_n <= !hit;
        end
        else
        begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule : ltt_target_model

// ==== lock_end_and_transfer_tracker_tb_top.sv ====
// Self-checking testbench of the lock end and transfer tracker.
`timescale 1ns/1ps
module lock_end_and_transfer_tracker_tb_top;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic proc_reset_n = 1'b1;
    logic strobe_n = 1'b1;
    logic grant_n = 1'b0;
    logic rw = 1'b1;
    logic [1:0] size = 2'h0;
    logic lock_n = 1'b1;
    logic [1:0] wait_cycles = 2'h0;
    logic [1:0] fault_mode = 2'h0;
    logic [1:0] fault_at = 2'h0;
    logic strobe_out_n, lock_end_n, tip_o, tip_oe, ale, aoe, ack_n, err_n;
    wire tip_line;
    integer seed = 32'h1f39;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] rnd;

    // The line has a pull-up, so an undriven line reads idle.
    assign tip_line = tip_oe ? tip_o : 1'b1;

    always #5 mclk = ~mclk;

    ltt_top ltt_top_inst (.MCLK(mclk), .ARST_N(arst_n),
        .PROC_RESET_N(proc_reset_n), .TRANSFER_START_STROBE_N(strobe_n),
        .CYCLE_ACKNOWLEDGE_N(ack_n), .BUS_ERROR_N(err_n),
        .GRANT_INPUT_N(grant_n), .READ_WRITE(rw), .SIZE(size),
        .LOCK_N(lock_n), .TRANSFER_START_STROBE_OUT_N(strobe_out_n),
        .LOCK_END_N(lock_end_n), .TRANSFER_IN_PROGRESS_BIDIR_N_I(tip_line),
        .TRANSFER_IN_PROGRESS_BIDIR_N_O(tip_o),
        .TRANSFER_IN_PROGRESS_BIDIR_N_OE(tip_oe),
        .ADDRESS_LATCH_ENABLE(ale), .ADDRESS_OUTPUT_ENABLE(aoe));

    ltt_target_model ltt_target_model_inst (.mclk(mclk), .arst_n(arst_n),
        .tip_line_n(tip_line), .wait_cycles(wait_cycles),
        .fault_mode(fault_mode), .fault_at(fault_at),
        .ack_n(ack_n), .err_n(err_n));

    // ************************************************************
    // Checking helpers
    // ************************************************************
    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", compares, num_errors);
            if (num_errors == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask : complete_run

    task check(input logic [7:0] seen, input logic [7:0] exp);
        begin
            compares++;
            if (seen !== exp)
            begin
                num_errors++;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask : check

    function automatic int exp_acks(input logic [1:0] sz, input logic lk_n);
        return (sz == 2'h3 && lk_n) ? 4 : 1;
    endfunction : exp_acks

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            complete_run();
        end
    end

    // ************************************************************
    // Bus cycle tasks
    // ************************************************************
    task automatic xfer(input logic r, input logic [1:0] sz, input logic le);
        int acks;
        int n;
        begin
            acks = 0;
            rnd = $random(seed);
            @(posedge mclk);
            strobe_n <= 1'b0;
            rw <= r;
            size <= sz;
            wait_cycles <= rnd[1:0];
            @(posedge mclk);
            n = exp_acks(sz, lock_n);
            strobe_n <= 1'b1;
            #1;
            check(strobe_out_n, 1'b0);
            check({ale, tip_oe, tip_o}, 3'b010);
            check(lock_end_n, !le);
            check(aoe, 1'b1);
            for (int i = 0; i < 300 && acks < n; i++)
            begin
                @(posedge mclk);
                check(tip_o, 1'b0);
                check(lock_end_n, !le);
                if (!err_n)
                    acks = n;
                else if (!ack_n)
                    acks++;
            end
            #1;
            // A dead clock follows every cycle before the next strobe.
            check({ale, tip_o, lock_end_n}, 3'b111);
        end
    endtask : xfer

    task automatic locked_seq(input int nr, input int nw);
        begin
            @(posedge mclk);
            lock_n <= 1'b0;
            for (int i = 0; i < nr; i++)
                xfer(1'b1, rnd[3:2], 1'b0);
            for (int i = 1; i <= nw; i++)
                xfer(1'b0, rnd[5:4], i == nr);
            lock_n <= 1'b1;
            @(posedge mclk);
        end
    endtask : locked_seq

    task automatic faulty(input logic [1:0] md, input logic [1:0] at,
                          input logic [1:0] sz);
        begin
            @(posedge mclk);
            fault_mode <= md;
            fault_at <= at;
            xfer(1'b1, sz, 1'b0);
            fault_mode <= 2'h0;
        end
    endtask : faulty

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (12) @(posedge mclk);
        check({strobe_out_n, lock_end_n, tip_o, tip_oe, aoe, ale},
              6'b111001);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        xfer(1'b1, 2'h0, 1'b0);
        xfer(1'b0, 2'h2, 1'b0);
        xfer(1'b1, 2'h3, 1'b0);
        xfer(1'b0, 2'h3, 1'b0);
        $display("test singles and bursts done");
        for (int k = 1; k <= 4; k++)
            locked_seq(k, k);
        $display("test locked sequences done");
        // Lock dropped mid-sequence: the next sequence must count afresh.
        locked_seq(2, 0);
        xfer(1'b0, 2'h0, 1'b0);
        locked_seq(1, 1);
        // Lock dropped in a locked data phase abandons the sequence.
        lock_n <= 1'b0;
        xfer(1'b1, 2'h0, 1'b0);
        @(posedge mclk);
        strobe_n <= 1'b0;
        @(posedge mclk);
        strobe_n <= 1'b1;
        lock_n <= 1'b1;
        @(negedge ack_n);
        @(posedge mclk);
        locked_seq(1, 1);
        $display("test abandoned lock done");
        lock_n <= 1'b0;
        xfer(1'b1, 2'h0, 1'b0);
        xfer(1'b1, 2'h0, 1'b0);
        faulty(2'h1, 2'h0, 2'h0);
        lock_n <= 1'b1;
        locked_seq(1, 1);
        faulty(2'h2, 2'h1, 2'h3);
        faulty(2'h1, 2'h2, 2'h3);
        xfer(1'b1, 2'h0, 1'b0);
        $display("test error and retry done");
        lock_n <= 1'b0;
        xfer(1'b1, 2'h1, 1'b0);
        @(posedge mclk);
        proc_reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        proc_reset_n <= 1'b1;
        locked_seq(1, 1);
        $display("test processor reset done");
        lock_n <= 1'b0;
        xfer(1'b1, 2'h0, 1'b0);
        @(posedge mclk);
        grant_n <= 1'b1;
        xfer(1'b1, 2'h1, 1'b0);
        xfer(1'b0, 2'h0, 1'b0);
        xfer(1'b0, 2'h0, 1'b1);
        lock_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check({tip_oe, aoe}, 2'b00);
        @(posedge mclk);
        grant_n <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        check({tip_oe, aoe}, 2'b11);
        $display("test grant loss done");
        for (int k = 0; k < 12; k++)
        begin
            rnd = $random(seed);
            if (rnd[8])
                locked_seq(1 + rnd[7:6], 1 + rnd[7:6]);
            else
                xfer(rnd[9], rnd[11:10], 1'b0);
        end
        $display("test random traffic done");
        complete_run();
    end
endmodule : lock_end_and_transfer_tracker_tb_top
